/* design/afl_alarm_top.sv */
// What this block does
// R1: alarm drives pin only in alarm function
// R2: three alarm drive styles selectable
// R3: serial role drives pin open-drain only
// R4: live bits 15..13 show safety summaries
// R5: bits 12, 11 show masked alerts
// R6: bits 10, 9 show init begun, done
// R7: bit 7 sets after first full loop
// R8: bits 6..4 show FETs off, stack low
// R9: bit 3 fuse driven, bit 2 balancing
// R10: bit 1 single scan, bit 0 wake
// R11: enabled rising flag latches status bit
// R12: scan flags latch at every completion
// R13: default and alert masks choose latching
// R14: enable mask readable and writable anytime
// R15: interrupt is OR of latched word
// R16: write one clears, zero leaves bit
// R17: pin state readable in fet status
// R18: latched word clears at reset
// R19: set beats simultaneous clear
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module afl_alarm_top
  import afl_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [9:0]        paddr,
  input  wire logic [AFL_DW-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [AFL_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire afl_flags_t        flags_in,
  input  wire afl_scan_t         scan_in,
  input  wire logic              serial_drive_low,
  input  wire logic              pin_in,
  output logic                   pin_out,
  output logic                   pin_oe,
  output logic                   alarm_irq
);

  // status inputs come from other logic domains: two stages each
  afl_flags_t flags_s1;
  afl_flags_t flags;
  afl_scan_t  scan_s1;
  afl_scan_t  scan;
  logic       pin_s1;
  logic       pin_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_s1 <= '0;
      flags    <= '0;
      scan_s1  <= '0;
      scan     <= '0;
      pin_s1   <= 1'b0;
      pin_sync <= 1'b0;
    end else if (ce) begin
      flags_s1 <= flags_in;
      flags    <= flags_s1;
      scan_s1  <= scan_in;
      scan     <= scan_s1;
      pin_s1   <= pin_in;
      pin_sync <= pin_s1;
    end
  end

  // scan pulses arrive as toggles so none is lost in the crossing
  afl_scan_t scan_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_prev <= '0;
    end else if (ce) begin
      scan_prev <= scan;
    end
  end
  wire single_scan_evt = scan.single_scan_pulse ^ scan_prev.single_scan_pulse;
  wire full_loop_evt   = scan.full_loop_pulse ^ scan_prev.full_loop_pulse;

  // live flags
  wire masked_safety_alert = |(flags.safety_alert & flags.safety_alert_mask); // R5
  wire masked_failure_alert = |(flags.fail_alert & flags.fail_alert_mask); // R5

  logic [AFL_FW-1:0] live;
  always_comb begin
    live                    = '0;
    live[AFL_B_SEC_SAFETY]  = flags.sec_safety_any; // R4
    live[AFL_B_PRI_SAFETY]  = flags.pri_safety_any; // R4
    live[AFL_B_PERM_FAIL]   = flags.perm_fail_any; // R4
    live[AFL_B_MSK_SAFETY]  = masked_safety_alert; // R5
    live[AFL_B_MSK_FAIL]    = masked_failure_alert; // R5
    live[AFL_B_INIT_BEGUN]  = flags.init_begun; // R6
    live[AFL_B_INIT_DONE]   = flags.init_done; // R6
    live[AFL_B_FULL_LOOP]   = flags.full_loop_done; // R7
    live[AFL_B_CHG_OFF]     = flags.charge_fet_off; // R8
    live[AFL_B_DSG_OFF]     = flags.discharge_fet_off; // R8
    live[AFL_B_STACK_LOW]   = flags.stack_below_shutdown; // R8
    live[AFL_B_FUSE]        = flags.fuse_driven; // R9
    live[AFL_B_BALANCE]     = flags.balancing; // R9
    live[AFL_B_SINGLE_SCAN] = flags.single_scan_done; // R10
    live[AFL_B_WAKE]        = flags.wake; // R10
  end

  // R7 R10: sticky scan bits hold once set
  logic              full_seen;
  logic              single_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_seen   <= 1'b0;
      single_seen <= 1'b0;
    end else if (ce) begin
      full_seen   <= full_seen | flags.full_loop_done | full_loop_evt; // R7
      single_seen <= single_seen | flags.single_scan_done | single_scan_evt; // R10
    end
  end

  wire [AFL_FW-1:0] live_word = (live
                               | ({{(AFL_FW-1){1'b0}}, full_seen} << AFL_B_FULL_LOOP)
                               | ({{(AFL_FW-1){1'b0}}, single_seen} << AFL_B_SINGLE_SCAN))
                               & AFL_RESERVED_MASK; // R10

  // registers
  logic [AFL_FW-1:0] enable_mask;
  logic [3:0]        pin_cfg;
  logic [AFL_FW-1:0] latched;

  wire acc       = psel & penable;
  // writes land only on the answer edge, so a clear acts once and cannot eat a fresh set
  wire wr        = acc & pwrite & pready; // R16 R19
  wire lo_strobe = pstrb[0];
  wire hi_strobe = pstrb[1];
  wire hit_latch = paddr == AFL_BUS_LATCHED;
  wire hit_live  = paddr == AFL_BUS_LIVE;
  wire hit_en    = paddr == AFL_BUS_ENABLE;
  wire hit_cfg   = paddr == AFL_BUS_PINCFG;
  wire hit_fet   = paddr == AFL_BUS_FETSTAT;
  wire mapped    = hit_latch | hit_live | hit_en | hit_cfg | hit_fet;
  wire ro_write  = pwrite & (hit_live | hit_fet);

  wire [AFL_FW-1:0] lane_mask = {{8{hi_strobe}}, {8{lo_strobe}}};
  wire [AFL_FW-1:0] wdata16   = pwdata[AFL_FW-1:0] & lane_mask;

  wire [AFL_FW-1:0] next_enable =
    (wr & hit_en) ? ((enable_mask & ~lane_mask) | wdata16) : enable_mask; // R14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_mask <= AFL_ENABLE_RESET;
      pin_cfg     <= '0;
    end else if (ce) begin
      enable_mask <= next_enable & AFL_RESERVED_MASK; // R13
      if (wr & hit_cfg & lo_strobe) begin
        pin_cfg <= pwdata[3:0];
      end
    end
  end

  // latched status
  wire [AFL_FW-1:0] clear_bits = (wr & hit_latch) ? wdata16 : '0; // R16
  wire [AFL_FW-1:0] force_bits =
    ({{(AFL_FW-1){1'b0}}, full_loop_evt} << AFL_B_FULL_LOOP)
    | ({{(AFL_FW-1){1'b0}}, single_scan_evt} << AFL_B_SINGLE_SCAN); // R12

  genvar gi;
  generate
    for (gi = 0; gi < AFL_FW; gi++) begin : g_bit
      afl_edge_latch u_latch (
        .pclk    (pclk),
        .presetn (presetn), // R18
        .ce      (ce),
        .flag    (live_word[gi]),
        .force_set(force_bits[gi]),
        .enable  (enable_mask[gi]), // R11 R13
        .clear   (clear_bits[gi]), // R16 R19
        .latched (latched[gi])
      );
    end
  endgenerate

  // pin
  wire      any_alarm = |latched; // R15
  afl_pin_t pin;

  afl_pin_drive u_pin (
    .pclk             (pclk),
    .presetn          (presetn),
    .ce               (ce),
    .fxn              (pin_cfg[AFL_PC_FXN_LSB +: 2]), // R1
    .style            (pin_cfg[AFL_PC_STYLE_LSB +: 2]), // R2
    .alarm            (any_alarm),
    .serial_drive_low (serial_drive_low), // R3
    .pin              (pin)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_irq <= 1'b0;
    end else if (ce) begin
      alarm_irq <= any_alarm; // R15
    end
  end

  assign pin_out = pin.out;
  assign pin_oe  = pin.oe;

  // APB read and answer
  logic [AFL_DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_latch) rd_mux[AFL_FW-1:0] = latched;
    if (hit_live)  rd_mux[AFL_FW-1:0] = live_word;
    if (hit_en)    rd_mux[AFL_FW-1:0] = enable_mask; // R14
    if (hit_cfg)   rd_mux[3:0]        = pin_cfg;
    if (hit_fet)   rd_mux[AFL_FET_PIN_BIT] = pin_sync; // R17
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (ce) begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & (~mapped | ro_write);
      prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : '0;
    end
  end

endmodule

/* design/afl_edge_latch.sv */
`timescale 1ns/1ps
module afl_edge_latch
  import afl_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic flag,
  input  wire logic force_set,
  input  wire logic enable,
  input  wire logic clear,
  output logic      latched
);

  logic flag_prev;
  wire  rise     = flag & ~flag_prev;
  wire  next_set = enable & (rise | force_set);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_prev <= 1'b0;
      latched   <= 1'b0;
    end else if (ce) begin
      flag_prev <= flag;
      // set beats clear so a same-cycle event is kept
      latched   <= next_set | (latched & ~clear);
    end
  end

endmodule

/* design/afl_pin_drive.sv */
`timescale 1ns/1ps
module afl_pin_drive
  import afl_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic [1:0] fxn,
  input  wire logic [1:0] style,
  input  wire logic       alarm,
  input  wire logic       serial_drive_low,
  output afl_pin_t        pin
);

  afl_pin_t next_pin;

  always_comb begin
    next_pin = '{out: 1'b0, oe: 1'b0};
    if (fxn == AFL_FXN_ALARM) begin
      case (style)
        AFL_STYLE_LOW_OD:  next_pin = '{out: 1'b0, oe: alarm};
        AFL_STYLE_HIGH_PP: next_pin = '{out: alarm, oe: 1'b1};
        AFL_STYLE_LOW_PP:  next_pin = '{out: ~alarm, oe: 1'b1};
        default:           next_pin = '{out: 1'b0, oe: alarm};
      endcase
    end else if (fxn == AFL_FXN_SERIAL) begin
      // serial role only ever pulls low
      next_pin = '{out: 1'b0, oe: serial_drive_low};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= '{out: 1'b0, oe: 1'b0};
    end else if (ce) begin
      pin <= next_pin;
    end
  end

endmodule

/* design/afl_pkg.sv */
package afl_pkg;

  localparam int          AFL_DW      = 32;
  localparam int          AFL_AW      = 8;
  localparam int          AFL_FW      = 16;

  // register byte addresses
  localparam logic [7:0]  AFL_ADDR_LATCHED = 8'h62;
  localparam logic [7:0]  AFL_ADDR_LIVE    = 8'h64;
  localparam logic [7:0]  AFL_ADDR_ENABLE  = 8'h66;
  localparam logic [7:0]  AFL_ADDR_PINCFG  = 8'h68;
  localparam logic [7:0]  AFL_ADDR_FETSTAT = 8'h7F;

  // not all byte addresses are word aligned, so the bus address is 4x the index
  localparam logic [9:0]  AFL_BUS_LATCHED  = 10'h188;
  localparam logic [9:0]  AFL_BUS_LIVE     = 10'h190;
  localparam logic [9:0]  AFL_BUS_ENABLE   = 10'h198;
  localparam logic [9:0]  AFL_BUS_PINCFG   = 10'h1A0;
  localparam logic [9:0]  AFL_BUS_FETSTAT  = 10'h1FC;

  // live flag bit positions
  localparam int AFL_B_SEC_SAFETY  = 15;
  localparam int AFL_B_PRI_SAFETY  = 14;
  localparam int AFL_B_PERM_FAIL   = 13;
  localparam int AFL_B_MSK_SAFETY  = 12;
  localparam int AFL_B_MSK_FAIL    = 11;
  localparam int AFL_B_INIT_BEGUN  = 10;
  localparam int AFL_B_INIT_DONE   = 9;
  localparam int AFL_B_RESERVED    = 8;
  localparam int AFL_B_FULL_LOOP   = 7;
  localparam int AFL_B_CHG_OFF     = 6;
  localparam int AFL_B_DSG_OFF     = 5;
  localparam int AFL_B_STACK_LOW   = 4;
  localparam int AFL_B_FUSE        = 3;
  localparam int AFL_B_BALANCE     = 2;
  localparam int AFL_B_SINGLE_SCAN = 1;
  localparam int AFL_B_WAKE        = 0;

  // pin configuration register fields
  localparam int AFL_PC_FXN_LSB    = 0;
  localparam int AFL_PC_STYLE_LSB  = 2;

  localparam logic [1:0]  AFL_FXN_ALARM      = 2'h2;
  localparam logic [1:0]  AFL_FXN_SERIAL     = 2'h0;
  localparam logic [15:0] AFL_ENABLE_RESET   = 16'h0000;
  localparam logic [15:0] AFL_RESERVED_MASK  = 16'hFEFF;
  localparam int          AFL_FET_PIN_BIT    = 6;

  typedef enum logic [1:0] {
    AFL_STYLE_LOW_OD,
    AFL_STYLE_HIGH_PP,
    AFL_STYLE_LOW_PP
  } afl_style_t;

  typedef struct packed {
    logic       sec_safety_any;
    logic       pri_safety_any;
    logic       perm_fail_any;
    logic [2:0] safety_alert;
    logic [2:0] safety_alert_mask;
    logic [3:0] fail_alert;
    logic [3:0] fail_alert_mask;
    logic       init_begun;
    logic       init_done;
    logic       full_loop_done;
    logic       charge_fet_off;
    logic       discharge_fet_off;
    logic       stack_below_shutdown;
    logic       fuse_driven;
    logic       balancing;
    logic       single_scan_done;
    logic       wake;
  } afl_flags_t;

  typedef struct packed {
    logic single_scan_pulse;
    logic full_loop_pulse;
  } afl_scan_t;

  typedef struct packed {
    logic out;
    logic oe;
  } afl_pin_t;

endpackage

/* verification/afl_alarm_monitor.sv */
`timescale 1ns/1ps
module afl_alarm_monitor
  import afl_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [9:0]        paddr,
  input wire logic [AFL_DW-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              alarm_irq
);
  logic [2:0] since_clr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // cycles since the last completed write to the latched word, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_clr <= 3'h7;
    else if (pready && pwrite && paddr == AFL_BUS_LATCHED) since_clr <= 3'h0;
    else if (since_clr != 3'h7) since_clr <= since_clr + 3'h1;
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && ce && !pready;
  endsequence

  a_one_wait_state: assert property (s_setup ##1 s_access |=> pready)
    else $error("access phase not answered after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable && ce))
    else $error("ready without access phase");
  a_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data outside answer cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_live_readonly: assert property (pready && pwrite && paddr == AFL_BUS_LIVE |-> pslverr)
    else $error("write to live word not refused");
  a_enable_accepted: assert property (pready && paddr == AFL_BUS_ENABLE |-> !pslverr)
    else $error("enable mask access refused");
  a_irq_fall_clear: assert property ($fell(alarm_irq) |-> since_clr < 3'h4)
    else $error("interrupt dropped without a clear");
endmodule

bind afl_alarm_top afl_alarm_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .alarm_irq(alarm_irq));

/* verification/afl_pin_host.sv */
`timescale 1ns/1ps
module afl_pin_host
(
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  // host side pull-up: an undriven line reads high, never a stale value
  assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  import afl_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              ce;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [9:0]        paddr;
  logic [AFL_DW-1:0] pwdata;
  logic [AFL_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  afl_flags_t        flags_in;
  afl_flags_t        fl;
  afl_scan_t         scan_in;
  logic              serial_drive_low;
  logic              pin_in;
  logic              pin_out;
  logic              pin_oe;
  logic              alarm_irq;
  logic [AFL_DW-1:0] rd;
  logic              er;
  logic [15:0]       sticky;
  logic [1:0]        e;
  int                num_errors;
  int                check_count;
  // struct bit feeding each live bit; two entries where an alert needs its mask
  int pa[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 8, 9, 14, 21, 24, 25, 26};
  int pb[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 8, 9, 10, 18, 24, 25, 26};

  afl_alarm_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags_in(flags_in),
    .scan_in(scan_in), .serial_drive_low(serial_drive_low), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .alarm_irq(alarm_irq));
  afl_pin_host host (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      num_errors++;
      finish_test;
    end
  endtask

  task rdchk(input logic [9:0] a, input logic [15:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(rd[15:0], x)
  endtask

  // flag input to live word, latch and pin register take four edges
  task settle;
    repeat (5) @(posedge pclk);
  endtask

  function automatic afl_flags_t mk(input int b);
    afl_flags_t f;
    f = '0;
    f[pa[b]] = 1'b1;
    f[pb[b]] = 1'b1;
    return f;
  endfunction

  function automatic logic [1:0] pexp(input int s, input logic act);
    case (s)
      0: return act ? 2'b10 : 2'b00;
      1: return act ? 2'b11 : 2'b10;
      default: return act ? 2'b10 : 2'b11;
    endcase
  endfunction

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    flags_in = '0;
    scan_in = '0;
    serial_drive_low = 1'b0;
    num_errors = 0;
    check_count = 0;
    sticky = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(AFL_BUS_LATCHED, 16'h0000);
    rdchk(AFL_BUS_ENABLE, AFL_ENABLE_RESET);
    `CHK(alarm_irq, 1'b0)
    flags_in <= mk(0);
    settle;
    rdchk(AFL_BUS_LIVE, 16'h0001);
    rdchk(AFL_BUS_LATCHED, 16'h0000);
    apb(1'b1, AFL_BUS_ENABLE, 32'h0000_0001);
    rdchk(AFL_BUS_ENABLE, 16'h0001);
    rdchk(AFL_BUS_LATCHED, 16'h0000);
    flags_in <= '0;
    settle;
    flags_in <= mk(0);
    settle;
    rdchk(AFL_BUS_LATCHED, 16'h0001);
    apb(1'b1, AFL_BUS_ENABLE, 32'h0000_FFFF);
    rdchk(AFL_BUS_ENABLE, AFL_RESERVED_MASK);
    apb(1'b1, AFL_BUS_LATCHED, 32'h0000_0001);
    for (int b = 15; b >= 0; b--) begin
      if (b == 8) continue;
      flags_in <= mk(b);
      settle;
      rdchk(AFL_BUS_LIVE, 16'(1 << b) | sticky);
      rdchk(AFL_BUS_LATCHED, 16'(1 << b));
      `CHK(alarm_irq, 1'b1)
      apb(1'b1, AFL_BUS_LATCHED, 32'(1 << b));
      rdchk(AFL_BUS_LATCHED, 16'h0000);
      `CHK(alarm_irq, 1'b0)
      if (b == 7 || b == 1) sticky[b] = 1'b1;
    end
    fl = mk(12);
    fl.safety_alert_mask = 3'h2;
    flags_in <= fl;
    settle;
    rdchk(AFL_BUS_LIVE, sticky);
    for (int k = 0; k < 4; k++) begin
      scan_in <= scan_in ^ (k[0] ? 2'b01 : 2'b10);
      settle;
      rdchk(AFL_BUS_LATCHED, k[0] ? 16'h0080 : 16'h0002);
      apb(1'b1, AFL_BUS_LATCHED, k[0] ? 32'h80 : 32'h2);
    end
    flags_in <= mk(0) | mk(2);
    settle;
    rdchk(AFL_BUS_LATCHED, 16'h0005);
    apb(1'b1, AFL_BUS_LATCHED, 32'h0000_0001);
    rdchk(AFL_BUS_LATCHED, 16'h0004);
    // alarm stays active here, so a pin left idle proves the function gate
    for (int v = 0; v < 3; v++) begin
      serial_drive_low <= (v != 0);
      apb(1'b1, AFL_BUS_PINCFG, (v == 2) ? 32'h1 : 32'h0);
      settle;
      `CHK({pin_oe, pin_out}, (v == 1) ? 2'b10 : 2'b00)
    end
    for (int a = 1; a >= 0; a--) begin
      for (int s = 0; s < 3; s++) begin
        apb(1'b1, AFL_BUS_PINCFG, 32'(s << 2) | 32'(AFL_FXN_ALARM));
        settle;
        e = pexp(s, a[0]);
        `CHK({pin_oe, pin_out}, e)
        apb(1'b0, AFL_BUS_FETSTAT, 32'h0);
        `CHK(rd[AFL_FET_PIN_BIT], e[1] ? e[0] : 1'b1)
      end
      apb(1'b1, AFL_BUS_LATCHED, 32'h0000_0004);
      settle;
    end
    // a frozen clock enable must hold off a new edge until it runs again
    ce <= 1'b0;
    flags_in <= mk(0) | mk(2) | mk(3);
    settle;
    `CHK(alarm_irq, 1'b0)
    ce <= 1'b1;
    settle;
    rdchk(AFL_BUS_LATCHED, 16'h0008);
    apb(1'b1, AFL_BUS_LIVE, 32'h0000_FFFF);
    `CHK(er, 1'b1)
    apb(1'b0, 10'h3FC, 32'h0);
    `CHK(er, 1'b1)
    finish_test;
  end
endmodule
